// [logic/ddrm_mode_regs.sv]
// Purpose: Captures the mode and extended mode registers from mode-set cycles.
// Assumes: Command pins are sampled on pclk; software watches the block over APB.
// Notes: Contents are cleared at reset only so that the outputs are defined.
module ddrm_mode_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ddrm_pkg::ddrm_cmd_t cmd,
   output logic [3:0] burst_len,
   output logic burst_interleaved,
   output logic [1:0] lat_cycles,
   output logic lat_half,
   output logic dll_enable,
   output logic drive_weak,
   output logic dll_reset_pulse,
   output logic mode_busy,
   output logic rd_first_data,
   output logic rd_first_half
);

   logic [ddrm_pkg::WORD_W-1:0] mode_word;
   logic [ddrm_pkg::WORD_W-1:0] ext_word;
   logic [7:0] status;
   logic accept_en;
   ddrm_pkg::ddrm_state_t state;
   logic [1:0] settle_cnt;
   logic mode_set;
   logic take_set;
   logic early_cmd;
   logic rd_cmd;
   logic apb_wr;
   logic apb_rd;
   logic [7:0] next_status;

   // Decoded command strobes, shared by capture, timing and the read path.
   assign mode_set = ddrm_pkg::is_mode_set(cmd);
   assign early_cmd = state == ddrm_pkg::MS_SETTLE && ddrm_pkg::is_command(cmd);
   assign take_set = mode_set && accept_en && !early_cmd;
   assign rd_cmd = cmd.cke && !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
   // A write lands only at the edge where pready is seen high, as the master expects.
   assign apb_wr = psel && penable && pwrite && pready;
   assign apb_rd = psel && penable && !pwrite && !pready;

   // Capture the full address and bank word into the selected register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_word <= ddrm_pkg::WORD_RESET;
         ext_word <= ddrm_pkg::WORD_RESET;
      end else if (take_set) begin
         if (cmd.ba[0]) begin
            ext_word <= {cmd.ba, cmd.addr};
         end else begin
            mode_word <= {cmd.ba, cmd.addr};
         end
      end
   end

   // Ordinary register fields drive the burst and latency outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_len <= 4'h0;
         burst_interleaved <= 1'b0;
         lat_cycles <= 2'd0;
         lat_half <= 1'b0;
      end else if (take_set && !cmd.ba[0]) begin
         unique case (cmd.addr[ddrm_pkg::BL_LSB +: 3])
            ddrm_pkg::BL_2: burst_len <= 4'h2;
            ddrm_pkg::BL_4: burst_len <= 4'h4;
            ddrm_pkg::BL_8: burst_len <= 4'h8;
            default: burst_len <= 4'h0;
         endcase
         burst_interleaved <= cmd.addr[ddrm_pkg::BT_BIT];
         unique case (cmd.addr[ddrm_pkg::CL_LSB +: 3])
            ddrm_pkg::CL_2: begin
               lat_cycles <= 2'd2;
               lat_half <= 1'b0;
            end
            ddrm_pkg::CL_3: begin
               lat_cycles <= 2'd3;
               lat_half <= 1'b0;
            end
            ddrm_pkg::CL_25: begin
               lat_cycles <= 2'd2;
               lat_half <= 1'b1;
            end
            default: begin
               lat_cycles <= 2'd0;
               lat_half <= 1'b0;
            end
         endcase
      end
   end

   // Extended register fields; a low enable bit keeps the loop running.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_enable <= 1'b0;
         drive_weak <= 1'b0;
      end else if (take_set && cmd.ba[0]) begin
         dll_enable <= !cmd.addr[ddrm_pkg::DLL_BIT];
         drive_weak <= cmd.addr[ddrm_pkg::DS_BIT];
      end
   end

   // A DLL reset request is a single-cycle pulse on the accepted write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_reset_pulse <= 1'b0;
      end else begin
         dll_reset_pulse <= take_set && !cmd.ba[0] &&
            cmd.addr[ddrm_pkg::TM_LSB +: 2] == ddrm_pkg::TM_DLL_RST;
      end
   end

   // Settle window after every accepted mode-set; busy covers it exactly.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ddrm_pkg::MS_IDLE;
         settle_cnt <= 2'd0;
         mode_busy <= 1'b0;
      end else begin
         unique case (state)
            ddrm_pkg::MS_IDLE: begin
               if (take_set) begin
                  state <= ddrm_pkg::MS_SETTLE;
                  settle_cnt <= 2'd0;
                  mode_busy <= 1'b1;
               end
            end
            ddrm_pkg::MS_SETTLE: begin
               if (settle_cnt == ddrm_pkg::MRD_LAST) begin
                  state <= ddrm_pkg::MS_IDLE;
                  mode_busy <= 1'b0;
               end else begin
                  settle_cnt <= settle_cnt + 2'd1;
               end
            end
         endcase
      end
   end

   // Sticky error flags; a new event outranks a software clear in the same cycle.
   always_comb begin
      next_status = status;
      if (apb_wr && paddr == ddrm_pkg::OFF_STAT) begin
         next_status = status & ~(pwdata[7:0] & ddrm_pkg::ST_STICKY);
      end
      next_status[ddrm_pkg::ST_BUSY] = 1'b0;
      if (take_set && !cmd.ba[0]) begin
         next_status[ddrm_pkg::ST_MODE_OK] = 1'b1;
         if (!ddrm_pkg::cl_legal(cmd.addr[ddrm_pkg::CL_LSB +: 3])) begin
            next_status[ddrm_pkg::ST_CL_ERR] = 1'b1;
         end
         if (!ddrm_pkg::bl_legal(cmd.addr[ddrm_pkg::BL_LSB +: 3])) begin
            next_status[ddrm_pkg::ST_BL_ERR] = 1'b1;
         end
         if (cmd.addr[ddrm_pkg::TM_LSB +: 2] != ddrm_pkg::TM_NORMAL &&
             cmd.addr[ddrm_pkg::TM_LSB +: 2] != ddrm_pkg::TM_DLL_RST) begin
            next_status[ddrm_pkg::ST_TM_ERR] = 1'b1;
         end
      end
      if (take_set && cmd.ba[0]) begin
         next_status[ddrm_pkg::ST_EXT_OK] = 1'b1;
      end
      if (take_set && cmd.ba[1]) begin
         next_status[ddrm_pkg::ST_BA1_ERR] = 1'b1;
      end
      if (early_cmd) begin
         next_status[ddrm_pkg::ST_TIME_ERR] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 8'h00;
      end else begin
         status <= next_status;
      end
   end

   // Software gate: with accept_en low, mode-set cycles are ignored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_en <= ddrm_pkg::CTRL_RESET[0];
      end else if (apb_wr && paddr == ddrm_pkg::OFF_CTRL) begin
         accept_en <= pwdata[0];
      end
   end

   // One wait state keeps prdata and pready straight from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && penable && !pready) begin
            unique case (paddr)
               ddrm_pkg::OFF_MODE: prdata <= apb_rd ? 32'(mode_word) : 32'h0000_0000;
               ddrm_pkg::OFF_EXT: prdata <= apb_rd ? 32'(ext_word) : 32'h0000_0000;
               ddrm_pkg::OFF_STAT: prdata <= apb_rd ? {24'h000000, status[7:3], mode_busy, status[1:0]} :
                  32'h0000_0000;
               ddrm_pkg::OFF_CTRL: prdata <= apb_rd ? {31'h0, accept_en} : 32'h0000_0000;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Read-latency pipeline toward the data path.
   ddrm_rd_lat u_rd_lat (
      .pclk(pclk),
      .presetn(presetn),
      .rd_cmd(rd_cmd),
      .lat_cycles(lat_cycles),
      .lat_half(lat_half),
      .first_data(rd_first_data),
      .first_half(rd_first_half)
   );

   // Assertions guarding the documented behaviour.
   sequence s_ext_set;
      take_set && cmd.ba[0];
   endsequence

   sequence s_settle;
      mode_busy [*2] ##1 !mode_busy;
   endsequence

   a_ext_capture: assert property (@(posedge pclk) disable iff (!presetn)
      s_ext_set |=> ext_word == $past({cmd.ba, cmd.addr}))
      else $error("extended word not captured");

   a_mode_bank_sel: assert property (@(posedge pclk) disable iff (!presetn)
      (take_set && !cmd.ba[0]) |=> $stable(ext_word))
      else $error("ordinary write touched extended word");

   a_settle_two: assert property (@(posedge pclk) disable iff (!presetn)
      take_set |=> s_settle)
      else $error("settle window not two cycles");

   a_dll_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      s_ext_set |=> dll_enable == !$past(cmd.addr[0]))
      else $error("dll enable polarity wrong");

   a_drive_strength: assert property (@(posedge pclk) disable iff (!presetn)
      s_ext_set |=> drive_weak == $past(cmd.addr[1]))
      else $error("drive strength not taken");

   a_latency_code: assert property (@(posedge pclk) disable iff (!presetn)
      (take_set && !cmd.ba[0] && cmd.addr[6:4] == 3'h6) |=> lat_cycles == 2'd2 && lat_half)
      else $error("latency 2.5 decode wrong");

   a_burst_len: assert property (@(posedge pclk) disable iff (!presetn)
      (take_set && !cmd.ba[0] && cmd.addr[2:0] == 3'h3) |=> burst_len == 4'h8)
      else $error("burst length 8 decode wrong");

   a_persist_regs: assert property (@(posedge pclk) disable iff (!presetn)
      !take_set |=> $stable(mode_word) && $stable(ext_word))
      else $error("register changed without mode-set");

   a_rd_lat_three: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_cmd && lat_cycles == 2'd3 && !take_set) ##1 (!take_set) [*2] |=> rd_first_data)
      else $error("first data not three cycles after read");

   a_dll_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (take_set && !cmd.ba[0] && cmd.addr[8:7] == 2'h2) |=> dll_reset_pulse ##1 !dll_reset_pulse)
      else $error("dll reset pulse missing");

   a_mode_capture: assert property (@(posedge pclk) disable iff (!presetn)
      (take_set && !cmd.ba[0]) |=> mode_word == $past({cmd.ba, cmd.addr}))
      else $error("ordinary word not captured");

   a_latency_three: assert property (@(posedge pclk) disable iff (!presetn)
      (take_set && !cmd.ba[0] && cmd.addr[6:4] == 3'h3) |=> lat_cycles == 2'd3 && !lat_half)
      else $error("latency 3 decode wrong");

   // A mode-set inside the settle window must leave both words alone and raise the timing flag.
   a_settle_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_set && mode_busy) |=> $stable(mode_word) && $stable(ext_word) && status[ddrm_pkg::ST_TIME_ERR])
      else $error("mode-set taken inside settle window");

endmodule

// [logic/ddrm_pkg.sv]
// Purpose: Shared constants, types and decode helpers for the mode-register block.
// Assumes: One clock (pclk) stands in for the memory clock; command pins are synchronous to it.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
package ddrm_pkg;

   // APB register byte offsets.
   localparam logic [11:0] OFF_MODE = 12'h000;
   localparam logic [11:0] OFF_EXT = 12'h004;
   localparam logic [11:0] OFF_STAT = 12'h008;
   localparam logic [11:0] OFF_CTRL = 12'h00c;

   // Field positions inside the captured address word.
   localparam int BL_LSB = 0;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int TM_LSB = 7;
   localparam int DLL_BIT = 0;
   localparam int DS_BIT = 1;
   localparam int WORD_W = 15;

   // Field encodings.
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] CL_2 = 3'h2;
   localparam logic [2:0] CL_3 = 3'h3;
   localparam logic [2:0] CL_25 = 3'h6;
   localparam logic [1:0] TM_NORMAL = 2'h0;
   localparam logic [1:0] TM_DLL_RST = 2'h2;

   // Status bit positions.
   localparam int ST_MODE_OK = 0;
   localparam int ST_EXT_OK = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_CL_ERR = 3;
   localparam int ST_BL_ERR = 4;
   localparam int ST_TIME_ERR = 5;
   localparam int ST_TM_ERR = 6;
   localparam int ST_BA1_ERR = 7;
   localparam logic [7:0] ST_STICKY = 8'hf8;

   // Reset values and timing.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [WORD_W-1:0] WORD_RESET = 15'h0000;
   localparam int MRD_CYCLES = 2;
   localparam logic [1:0] MRD_LAST = 2'(MRD_CYCLES - 1);

   // Command pins as sampled on the rising clock edge.
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic [1:0] ba;
      logic [12:0] addr;
   } ddrm_cmd_t;

   typedef enum logic {
      MS_IDLE,
      MS_SETTLE
   } ddrm_state_t;

   // A mode-set cycle: all four strobes low with clock enable high.
   function automatic logic is_mode_set(input ddrm_cmd_t c);
      return c.cke && !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;
   endfunction

   // Any command other than deselect or no-operation.
   function automatic logic is_command(input ddrm_cmd_t c);
      return !c.cs_n && !(c.ras_n && c.cas_n && c.we_n);
   endfunction

   function automatic logic cl_legal(input logic [2:0] code);
      return code == CL_2 || code == CL_3 || code == CL_25;
   endfunction

   function automatic logic bl_legal(input logic [2:0] code);
      return code == BL_2 || code == BL_4 || code == BL_8;
   endfunction

endpackage

// [logic/ddrm_rd_lat.sv]
// Purpose: Delays a registered read command by the programmed read latency.
// Assumes: Latency is 2 or 3 whole clocks, with a flag adding half a clock.
// Notes: The half clock cannot be shown on a single-edge clock, so it is carried as a flag.
module ddrm_rd_lat (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rd_cmd,
   input wire logic [1:0] lat_cycles,
   input wire logic lat_half,
   output logic first_data,
   output logic first_half
);

   logic [1:0] stage;

   // Stage 0 is one clock after the command, stage 1 two clocks after.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage <= 2'h0;
      end else begin
         stage <= {stage[0], rd_cmd};
      end
   end

   // First data marks the clock edge that is lat_cycles after the command.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_data <= 1'b0;
         first_half <= 1'b0;
      end else begin
         first_data <= (lat_cycles == 2'd3) ? stage[1] : stage[0];
         first_half <= lat_half;
      end
   end

endmodule

// [testbench/ddrm_ctrl_model.sv]
// Purpose: Behavioural memory controller that drives the command pins.
// Assumes: Each task starts by waiting for a rising edge and drives right after it.
// Notes: Idle cycles show the inverted address, so a stale value never looks valid.
module ddrm_ctrl_model (
   input wire logic pclk,
   output ddrm_pkg::ddrm_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock enable is high from time zero, so no mode-set ever meets it low.
   initial begin
      cmd = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, ba: 2'h0, addr: 13'h0000};
   end

   // One command for the coming edge; s holds the strobes cs, ras, cas, we.
   task automatic issue(input logic [3:0] s, input logic [1:0] ba, input logic [12:0] a);
      @(posedge pclk);
      cmd <= '{cs_n: s[3], ras_n: s[2], cas_n: s[1], we_n: s[0], cke: 1'b1, ba: ba, addr: a};
   endtask

   // Deselect; the bank and address lines flip so nothing stale is held.
   task automatic idle();
      @(posedge pclk);
      cmd <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, ba: ~cmd.ba, addr: ~cmd.addr};
   endtask

   // Mode-set, then a deselect and one more edge of the settle gap.
   task automatic mode_set(input logic [1:0] ba, input logic [12:0] a);
      issue(4'h0, ba, a);
      idle();
      @(posedge pclk);
   endtask
endmodule

// [testbench/tb_ddr_mode_register_programming.sv]
// Purpose: Self-checking bench for the mode-register block.
// Assumes: APB answers after one wait state; the model owns the command pins.
// Notes: Pulse widths are counted by a monitor, so checks never race an edge.
module tb_ddr_mode_register_programming;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr;
   ddrm_pkg::ddrm_cmd_t cmd;
   logic [3:0] burst_len;
   logic [1:0] lat_cycles;
   logic burst_interleaved, lat_half, dll_enable, drive_weak, dll_reset_pulse, mode_busy;
   logic rd_first_data, rd_first_half;
   logic [2:0] clc [3] = '{ddrm_pkg::CL_2, ddrm_pkg::CL_3, ddrm_pkg::CL_25};
   logic [2:0] blc [3] = '{ddrm_pkg::BL_2, ddrm_pkg::BL_4, ddrm_pkg::BL_8};
   int len [3] = '{2, 4, 8};
   int cyc [3] = '{2, 3, 2};
   int half [3] = '{0, 0, 1};
   int n_fail = 0;
   int total_checks = 0;
   int n_busy = 0;
   int n_dll = 0;

   // Free-running clock at 40 MHz.
   always #12.5 pclk = ~pclk;

   ddrm_mode_regs dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .cmd, .burst_len, .burst_interleaved, .lat_cycles, .lat_half, .dll_enable, .drive_weak, .dll_reset_pulse,
      .mode_busy, .rd_first_data, .rd_first_half);
   ddrm_ctrl_model ctl (.pclk, .cmd);

   // Counts high cycles of the pulse outputs.
   always @(posedge pclk) begin
      if (mode_busy === 1'b1) n_busy <= n_busy + 1;
      if (dll_reset_pulse === 1'b1) n_dll <= n_dll + 1;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         summarize();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdata, exp);
   endtask

   // Read command, then count edges until first data shows.
   task automatic rd_lat(input int exp_n, input int exp_h);
      int n;
      ctl.issue(4'h5, 2'h0, 13'h0000);
      ctl.idle();
      n = 1;
      #1;
      while (rd_first_data !== 1'b1 && n < 8) begin
         @(posedge pclk);
         n++;
         #1;
      end
      if (n >= 8) begin
         n_fail++;
         summarize();
      end
      chk(n, exp_n);
      chk(rd_first_half, exp_h);
   endtask

   initial begin
      int b;
      logic [12:0] a;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      reg_rd(ddrm_pkg::OFF_MODE, 32'h0000_0000);
      reg_rd(ddrm_pkg::OFF_STAT, 32'h0000_0000);
      reg_rd(ddrm_pkg::OFF_CTRL, ddrm_pkg::CTRL_RESET);
      reg_rd(12'h010, 32'h0000_0000);
      chk(rerr, 1'b1);
      $display("test reset done");
      // The extended register is set up before any read traffic.
      ctl.mode_set(2'h1, 13'h0002);
      #1;
      chk(dll_enable, 1'b1);
      chk(drive_weak, 1'b1);
      ctl.mode_set(2'h1, 13'h0001);
      #1;
      chk(dll_enable, 1'b0);
      chk(drive_weak, 1'b0);
      reg_rd(ddrm_pkg::OFF_EXT, 32'h0000_2001);
      $display("test extended done");
      // Every legal latency and burst code, with burst type alternating.
      for (int i = 0; i < 3; i++) begin
         a = {6'h00, clc[i], i[0], blc[i]};
         b = n_busy;
         ctl.mode_set(2'h0, a);
         #1;
         chk(burst_len, len[i]);
         chk(burst_interleaved, i[0]);
         chk(lat_cycles, cyc[i]);
         chk(lat_half, half[i]);
         reg_rd(ddrm_pkg::OFF_MODE, {19'h0, 2'h0, a});
         chk(n_busy - b, 2);
         rd_lat(cyc[i], half[i]);
      end
      chk(dll_enable, 1'b0);
      reg_rd(ddrm_pkg::OFF_EXT, 32'h0000_2001);
      $display("test latency table done");
      ctl.mode_set(2'h0, 13'h0004);
      #1;
      chk(lat_cycles, 2'h0);
      chk(burst_len, 4'h0);
      reg_rd(ddrm_pkg::OFF_STAT, 32'h0000_001b);
      apb(1'b1, ddrm_pkg::OFF_STAT, 32'h0000_00f8);
      reg_rd(ddrm_pkg::OFF_STAT, 32'h0000_0003);
      ctl.mode_set(2'h2, 13'h00a2);
      reg_rd(ddrm_pkg::OFF_MODE, 32'h0000_40a2);
      reg_rd(ddrm_pkg::OFF_STAT, 32'h0000_00c3);
      apb(1'b1, ddrm_pkg::OFF_STAT, 32'h0000_00f8);
      b = n_dll;
      ctl.mode_set(2'h0, 13'h0122);
      reg_rd(ddrm_pkg::OFF_STAT, 32'h0000_0003);
      chk(n_dll - b, 1);
      $display("test reserved codes done");
      // Second mode-set lands inside the settle window and must be refused.
      ctl.issue(4'h0, 2'h0, 13'h0031);
      ctl.issue(4'h0, 2'h0, 13'h0023);
      ctl.idle();
      repeat (2) @(posedge pclk);
      #1;
      chk(lat_cycles, 2'h3);
      chk(burst_len, 4'h2);
      reg_rd(ddrm_pkg::OFF_STAT, 32'h0000_0023);
      apb(1'b1, ddrm_pkg::OFF_CTRL, 32'h0000_0000);
      ctl.mode_set(2'h0, 13'h0023);
      #1;
      chk(burst_len, 4'h2);
      apb(1'b1, ddrm_pkg::OFF_CTRL, 32'h0000_0001);
      $display("test refusal done");
      summarize();
   end
endmodule
